// >>> shared/adc_host_pkg.sv
package adc_host_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONVERSION_TIME_NS = 3600;
  localparam int ACQUISITION_TIME_NS = 300;
  localparam int START_LOW_STD_NS = 35;
  localparam int START_LOW_EXT_NS = 45;
  localparam int READ_LOW_STD_NS = 35;
  localparam int READ_LOW_EXT_NS = 45;
  localparam int READ_GAP_NS = 40;
  localparam int DATA_ACCESS_EXT_NS = 70;
  localparam int RESULT_WIDTH = 12;
  localparam int CNT_WIDTH = 8;

  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int START_LOW_CYC = ns_to_cycles(START_LOW_EXT_NS);
  localparam int READ_LOW_CYC = ns_to_cycles(DATA_ACCESS_EXT_NS);
  localparam int READ_GAP_CYC = ns_to_cycles(READ_GAP_NS);
  localparam int ACQ_CYC = ns_to_cycles(ACQUISITION_TIME_NS);
  localparam int BUSY_TIMEOUT_CYC = ns_to_cycles(CONVERSION_TIME_NS) + 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BUSY = 3'b010,
    ST_READ = 3'b011,
    ST_GAP = 3'b100,
    ST_ACQ = 3'b101
  } host_state_e;
endpackage

// >>> logic/adc_host.sv
`timescale 1ns/10ps
module adc_host
  import adc_host_pkg::*;
#(
  // pin times in ns, and the clock period they are counted in
  parameter int CLK_PERIOD = CLK_PERIOD_NS,
  parameter int CONV_TIME = CONVERSION_TIME_NS,
  parameter int ACQ_TIME = ACQUISITION_TIME_NS,
  parameter int START_LOW = START_LOW_EXT_NS,
  parameter int READ_LOW = READ_LOW_EXT_NS,
  parameter int READ_ACCESS = DATA_ACCESS_EXT_NS,
  parameter int READ_GAP = READ_GAP_NS
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // user request
  input wire logic sample_req,
  input wire logic sample_pair_b,
  input wire logic bipolar,
  output logic sample_ready,
  output logic sample_valid,
  output logic [adc_host_pkg::RESULT_WIDTH-1:0] result_first,
  output logic [adc_host_pkg::RESULT_WIDTH-1:0] result_second,
  output logic result_pair_b,
  output logic busy_timeout,
  // converter pins
  output logic conversion_start_n,
  output logic chip_select_n,
  output logic read_n,
  output logic input_pair_select,
  input wire logic busy,
  input wire logic [adc_host_pkg::RESULT_WIDTH-1:0] result_bus
);
  import adc_host_pkg::*;

  host_state_e state, next_state;
  logic [CNT_WIDTH-1:0] cnt, next_cnt;
  logic second, next_second;
  logic [RESULT_WIDTH-1:0] next_result_first, next_result_second;
  logic next_sample_valid, next_result_pair_b, next_busy_timeout;
  logic next_input_pair_select;
  logic start_after_acq, next_start_after_acq;

  // whole cycles, never zero, so every minimum pin time holds at any period
  function automatic int cycles_of(input int ns);
    int c;
    c = (ns + CLK_PERIOD - 1) / CLK_PERIOD;
    return (c < 1) ? 1 : c;
  endfunction

  // the strobe must outlast both its own minimum and the data access time
  localparam int START_CYCLES = cycles_of(START_LOW);
  localparam int READ_CYCLES = (cycles_of(READ_ACCESS) > cycles_of(READ_LOW)) ?
    cycles_of(READ_ACCESS) : cycles_of(READ_LOW);
  localparam int GAP_CYCLES = cycles_of(READ_GAP);
  localparam int ACQ_CYCLES = cycles_of(ACQ_TIME);
  // margin past the slowest conversion before busy is taken as stuck
  localparam int TIMEOUT_CYCLES = cycles_of(CONV_TIME) +
    (BUSY_TIMEOUT_CYC - ns_to_cycles(CONVERSION_TIME_NS));
  localparam int CNT_LIMIT = 1 << CNT_WIDTH;

  // one down counter serves every wait, so the longest must fit in it
  if (CLK_PERIOD < 1) begin : g_bad_period
    $error("clock period must be positive");
  end
  if (TIMEOUT_CYCLES >= CNT_LIMIT || ACQ_CYCLES >= CNT_LIMIT || READ_CYCLES >= CNT_LIMIT ||
      START_CYCLES >= CNT_LIMIT || GAP_CYCLES >= CNT_LIMIT) begin : g_bad_count
    $error("a pin time does not fit the wait counter");
  end

  // sign flip on msb turns twos complement into offset binary for callers
  function automatic logic [RESULT_WIDTH-1:0] to_unsigned(input logic [RESULT_WIDTH-1:0] w,
                                                          input logic bip);
    return bip ? {~w[RESULT_WIDTH-1], w[RESULT_WIDTH-2:0]} : w;
  endfunction

  // handshake pins decode one state each, unregistered, so multi-bit state changes can glitch them
  assign sample_ready = (state == ST_IDLE);
  assign conversion_start_n = ~(state == ST_START);
  assign chip_select_n = ~(state == ST_READ);
  assign read_n = ~(state == ST_READ);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_second = second;
    next_result_first = result_first;
    next_result_second = result_second;
    next_sample_valid = 1'b0;
    next_result_pair_b = result_pair_b;
    next_busy_timeout = 1'b0;
    next_input_pair_select = input_pair_select;
    next_start_after_acq = start_after_acq;
    case (state)
      ST_IDLE: begin
        if (sample_req) begin
          next_input_pair_select = sample_pair_b;
          if (sample_pair_b != input_pair_select) begin
            // pair change needs fresh acquisition before sampling
            next_state = ST_ACQ;
            next_cnt = CNT_WIDTH'(ACQ_CYCLES);
            next_start_after_acq = 1'b1;
          end else begin
            next_state = ST_START;
            next_cnt = CNT_WIDTH'(START_CYCLES);
          end
        end
      end
      ST_START: begin
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_WIDTH'(1)) begin
          next_state = ST_BUSY;
          next_cnt = CNT_WIDTH'(TIMEOUT_CYCLES);
        end
      end
      ST_BUSY: begin
        next_cnt = cnt - 1'b1;
        // busy rose within a cycle of the start edge, so low here means done
        if (!busy) begin
          next_state = ST_READ;
          next_second = 1'b0;
          next_cnt = CNT_WIDTH'(READ_CYCLES);
        end else if (cnt == CNT_WIDTH'(1)) begin
          // stuck busy: give up and report, rather than hang forever
          next_busy_timeout = 1'b1;
          next_state = ST_ACQ;
          next_cnt = CNT_WIDTH'(ACQ_CYCLES);
        end
      end
      ST_READ: begin
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_WIDTH'(1)) begin
          // sample at end of strobe, after worst access time
          if (second) begin
            next_result_second = to_unsigned(result_bus, bipolar);
            next_result_pair_b = input_pair_select;
            next_sample_valid = 1'b1;
            next_state = ST_ACQ;
            next_cnt = CNT_WIDTH'(ACQ_CYCLES);
          end else begin
            next_result_first = to_unsigned(result_bus, bipolar);
            next_state = ST_GAP;
            next_cnt = CNT_WIDTH'(GAP_CYCLES);
          end
        end
      end
      ST_GAP: begin
        // both strobes high here lets the converter release the bus
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_WIDTH'(1)) begin
          next_state = ST_READ;
          next_second = 1'b1;
          next_cnt = CNT_WIDTH'(READ_CYCLES);
        end
      end
      ST_ACQ: begin
        next_cnt = cnt - 1'b1;
        if (cnt == CNT_WIDTH'(1)) begin
          next_second = 1'b0;
          next_start_after_acq = 1'b0;
          if (start_after_acq) begin
            // arrived here from a pair change: now start the conversion
            next_state = ST_START;
            next_cnt = CNT_WIDTH'(START_CYCLES);
          end else begin
            // after a result or a timeout, wait for the next request
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  // reset leaves every converter pin at its idle level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= '0;
      second <= 1'b0;
      result_first <= '0;
      result_second <= '0;
      sample_valid <= 1'b0;
      result_pair_b <= 1'b0;
      busy_timeout <= 1'b0;
      input_pair_select <= 1'b0;
      start_after_acq <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      second <= next_second;
      result_first <= next_result_first;
      result_second <= next_result_second;
      sample_valid <= next_sample_valid;
      result_pair_b <= next_result_pair_b;
      busy_timeout <= next_busy_timeout;
      input_pair_select <= next_input_pair_select;
      start_after_acq <= next_start_after_acq;
    end
  end
endmodule

// >>> test/adc_dev_model.sv
`timescale 1ns/10ps
module adc_dev_model(
  // pins from the host
  input wire logic sys_clk,
  input wire logic conversion_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic input_pair_select,
  // analog stand-ins and conversion length
  input wire logic [11:0] v [4],
  input wire logic [31:0] conv_cyc,
  // pins to the host
  output logic busy = 1'b0,
  output logic [11:0] result_bus
);
  logic [11:0] held [4];
  logic [11:0] last = 12'h000;
  logic start_q = 1'b1, rd_q = 1'b0, idx = 1'b0;
  int cnt = 0;
  wire rd = !chip_select_n && !read_n;
  // released bus shows the inverse, never a stale match; data only after access time
  assign result_bus = (rd && rd_q) ? held[{input_pair_select, idx}] : ~last;
  always @(posedge sys_clk) begin
    start_q <= conversion_start_n;
    rd_q <= rd;
    if (rd && rd_q) last <= result_bus;
    if (rd_q && !rd) idx <= ~idx;
    if (start_q && !conversion_start_n) begin
      held <= v;
      busy <= 1'b1;
      cnt <= conv_cyc;
      idx <= 1'b0;
    end else if (cnt > 1) cnt <= cnt - 1;
    else busy <= 1'b0;
  end
endmodule

// >>> test/adc_host_chk.sv
`timescale 1ns/10ps
module adc_host_chk(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // user request side
  input wire logic sample_req,
  input wire logic sample_pair_b,
  input wire logic sample_ready,
  input wire logic sample_valid,
  // converter pins
  input wire logic conversion_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic input_pair_select,
  input wire logic busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_acq;
    conversion_start_n [*8];
  endsequence
  AST_START_LOW: assert property ($fell(conversion_start_n) |=> !conversion_start_n)
    else $error("start short");
  AST_READ_LOW: assert property ($fell(read_n) |=> !read_n)
    else $error("read short");
  AST_CS_RD: assert property (read_n == chip_select_n)
    else $error("cs rd split");
  AST_NO_READ_BUSY: assert property (!read_n |-> !busy)
    else $error("read in busy");
  AST_BUSY_ACQ: assert property ($fell(busy) |=> s_acq)
    else $error("start early");
  // count from the sample that first shows the new pair: eight cycles cover 300 ns
  AST_PAIR_ACQ: assert property ($changed(input_pair_select) |-> s_acq)
    else $error("pair early");
  AST_TAKE: assert property (
    sample_ready && sample_req && sample_pair_b == input_pair_select |=> !conversion_start_n)
    else $error("no start");
  AST_VALID: assert property (sample_valid |-> !$past(read_n))
    else $error("valid early");
endmodule
bind adc_host adc_host_chk u_chk(.sys_clk, .rst_b, .sample_req, .sample_pair_b,
  .sample_ready, .sample_valid, .conversion_start_n, .chip_select_n, .read_n,
  .input_pair_select, .busy);

// >>> test/dual_sar_adc_parallel_readout_tb_top.sv
`timescale 1ns/10ps
module dual_sar_adc_parallel_readout_tb_top;
  import adc_host_pkg::*;
  logic sys_clk = 0, rst_b = 0, sample_req = 0, sample_pair_b = 0, bipolar = 0;
  logic sample_ready, sample_valid, result_pair_b, busy_timeout, busy;
  logic conversion_start_n, chip_select_n, read_n, input_pair_select;
  logic [RESULT_WIDTH-1:0] result_first, result_second, result_bus, v [4];
  int mismatches = 0, check_count = 0, cycles = 0, conv_cyc = 10, k;
  int seed = 32'h90fc_816a;
  adc_host u_adc_host(.sys_clk, .rst_b, .sample_req, .sample_pair_b, .bipolar, .sample_ready,
    .sample_valid, .result_first, .result_second, .result_pair_b, .busy_timeout,
    .conversion_start_n, .chip_select_n, .read_n, .input_pair_select, .busy, .result_bus);
  adc_dev_model u_adc_dev_model(.sys_clk, .conversion_start_n, .chip_select_n, .read_n,
    .input_pair_select, .v, .conv_cyc, .busy, .result_bus);
  initial forever #20 sys_clk = ~sys_clk;
  task automatic check(string n, logic [11:0] s, logic [11:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk) if (++cycles > 3000) begin
    mismatches++;
    report_and_stop;
  end
  task automatic request(bit p, bit b);
    while (sample_ready !== 1'b1) @(negedge sys_clk);
    sample_pair_b = p;
    bipolar = b;
    sample_req = 1;
    @(negedge sys_clk);
    sample_req = 0;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_b = 1;
    for (k = 0; k < 8; k++) begin
      foreach (v[i]) v[i] = RESULT_WIDTH'($random(seed));
      conv_cyc = 2 + $unsigned($random(seed)) % 80;
      request(k[1], k[0]);
      do @(negedge sys_clk); while (sample_valid !== 1'b1);
      // bipolar codes come back offset binary
      check("first", result_first, v[{k[1], 1'b0}] ^ {k[0], 11'h000});
      check("second", result_second, v[{k[1], 1'b1}] ^ {k[0], 11'h000});
      check("pair", {11'h000, result_pair_b}, {11'h000, k[1]});
    end
    conv_cyc = 120;
    request(1'b1, 1'b0);
    for (k = 0; k < 130 && busy_timeout !== 1'b1; k++) @(negedge sys_clk);
    check("timeout", {11'h000, busy_timeout}, 12'h001);
    check("tmo_late", {11'h000, k >= CONVERSION_TIME_NS / CLK_PERIOD_NS}, 12'h001);
    // an abandoned conversion must leave the controller idle, not restart it
    repeat (ACQ_CYC + 2) @(negedge sys_clk);
    check("tmo_idle", {11'h000, sample_ready & conversion_start_n}, 12'h001);
    report_and_stop;
  end
endmodule
